/* File: rtl/cclb_codec_ctl.sv */
// Control word, autocalibration, clock generation and loopback of the serial codec
`timescale 1ns/1ps
module cclb_codec_ctl (
    // Clock, reset and enable
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic                   ce,
    // Mode and power
    input  wire logic                   data_mode,
    input  wire logic                   power_down,
    // Serial link, one strobe per bit, sync on the first bit
    input  wire logic                   bit_strobe,
    input  wire logic                   frame_sync,
    input  wire logic                   serial_in_pin,
    output logic                        serial_out_pin,
    // Clock sources, sampled levels
    input  wire logic                   crystal_input_a,
    input  wire logic                   crystal_input_b,
    input  wire logic                   ext_clock_input,
    input  wire logic                   sclk_level,
    output logic                        clk256_out,
    // Converter side
    input  wire logic [31:0]            adc_data,
    output logic [31:0]                 dac_data,
    output logic                        dac_data_valid,
    output logic [31:0]                 data_ctl_word,
    output cclb_pkg::cclb_ana_ctl_s     ana_ctl,
    output logic                        calibrating_flag
);

    logic [63:0]                  cw;
    logic [63:0]                  rx_shift;
    logic [63:0]                  rx_next;
    logic [63:0]                  tx_shift;
    logic [63:0]                  tx_word;
    logic [cclb_pkg::ECHO_BITS-1:0] echo_line;
    logic [6:0]                   bit_cnt;
    logic                         frame_done;
    logic                         frame_start;
    logic                         data_mode_q;
    logic                         to_data;
    logic                         to_ctl;
    logic                         loop_dig;
    logic                         loop_ana;
    logic [7:0]                   cal_cnt;
    logic [12:0]                  phase_acc;
    logic [12:0]                  next_phase;
    logic [11:0]                  div_sel;
    logic                         src_lvl;
    logic                         src_q;
    logic                         direct_src;
    cclb_pkg::cclb_cal_state_e    cal_state;
    cclb_pkg::cclb_clk_src_e      clk_src;

    assign frame_start = bit_strobe && frame_sync;
    assign frame_done  = bit_strobe && !frame_sync && (bit_cnt == 7'(cclb_pkg::FRAME_BITS - 1));
    assign rx_next     = {rx_shift[62:0], serial_in_pin};
    assign to_data     = data_mode && !data_mode_q;
    assign to_ctl      = !data_mode && data_mode_q;
    assign loop_dig    = cw[cclb_pkg::BIT_LOOP_EN] && !cw[cclb_pkg::BIT_LOOP_ANA];
    assign loop_ana    = cw[cclb_pkg::BIT_LOOP_EN] && cw[cclb_pkg::BIT_LOOP_ANA];
    assign clk_src     = cclb_pkg::cclb_clk_src_e'(cw[cclb_pkg::CLKSRC_LSB +: 3]);

    // Mode tracking
    always_ff @(posedge clk) begin
        if (srst) begin
            data_mode_q <= 1'b0;
        end else if (ce) begin
            data_mode_q <= data_mode;
        end
    end

    // Frame bit counter and receive shifter, 64-bit word MSB first
    always_ff @(posedge clk) begin
        if (srst) begin
            bit_cnt  <= 7'h00;
            rx_shift <= 64'h0000_0000_0000_0000;
        end else if (ce && bit_strobe) begin
            rx_shift <= rx_next;
            bit_cnt  <= frame_sync ? 7'h01 : bit_cnt + 7'h01;
        end
    end

    // Control word storage
    always_ff @(posedge clk) begin
        if (srst) begin
            cw <= cclb_pkg::CW_DEFAULT;
        end else if (ce) begin
            if (power_down) begin
                cw <= cclb_pkg::CW_DEFAULT;
            end else if (to_ctl) begin
                cw <= (cw & ~cclb_pkg::CW_DATA_MASK)
                      | (cclb_pkg::CW_DEFAULT & cclb_pkg::CW_DATA_MASK);
            end else if (frame_done && !data_mode_q) begin
                cw <= ((cw & ~cclb_pkg::CW_CTL_MASK) | (rx_next & cclb_pkg::CW_CTL_MASK))
                      & ~cclb_pkg::CW_FIXED_MASK | cclb_pkg::CW_FIXED_VAL;
            end else if (frame_done && data_mode_q) begin
                cw <= (cw & ~cclb_pkg::CW_DATA_MASK) | (rx_next & cclb_pkg::CW_DATA_MASK);
            end
        end
    end

    // Autocalibration sequencer, also run on leaving reset
    always_ff @(posedge clk) begin
        if (srst) begin
            cal_state <= cclb_pkg::CAL_RUN;
            cal_cnt   <= 8'h00;
        end else if (ce) begin
            unique case (cal_state)
                cclb_pkg::CAL_IDLE: begin
                    if (to_data) begin
                        cal_state <= cclb_pkg::CAL_RUN;
                        cal_cnt   <= 8'h00;
                    end
                end
                cclb_pkg::CAL_RUN: begin
                    if (!data_mode_q && data_mode) begin
                        cal_cnt <= 8'h00;
                    end else if (frame_start) begin
                        if (cal_cnt == cclb_pkg::AUTOCAL_FRAMES - 8'h01) begin
                            cal_state <= cclb_pkg::CAL_IDLE;
                        end
                        cal_cnt <= cal_cnt + 8'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            calibrating_flag <= 1'b1;
        end else if (ce) begin
            calibrating_flag <= (cal_state == cclb_pkg::CAL_RUN);
        end
    end

    // Two-frame echo line, shifted on every received bit
    always_ff @(posedge clk) begin
        if (srst) begin
            echo_line <= '0;
        end else if (ce && bit_strobe) begin
            echo_line <= {echo_line[cclb_pkg::ECHO_BITS-2:0], serial_in_pin};
        end
    end

    // Readback word: control word in Control Mode, ADC data (zeros while calibrating) plus control in Data Mode
    always_comb begin
        if (!data_mode_q) begin
            tx_word = cw;
        end else if (cal_state == cclb_pkg::CAL_RUN) begin
            tx_word = {32'h0000_0000, cw[31:0]};
        end else begin
            tx_word = {adc_data, cw[31:0]};
        end
    end

    // Transmit shifter and serial output
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_shift       <= 64'h0000_0000_0000_0000;
            serial_out_pin <= 1'b0;
        end else if (ce && bit_strobe) begin
            if (frame_sync) begin
                tx_shift <= {tx_word[62:0], 1'b0};
            end else begin
                tx_shift <= {tx_shift[62:0], 1'b0};
            end
            if (loop_dig) begin
                serial_out_pin <= echo_line[cclb_pkg::ECHO_BITS-1];
            end else if (frame_sync) begin
                serial_out_pin <= tx_word[63];
            end else begin
                serial_out_pin <= tx_shift[63];
            end
        end
    end

    // DAC data capture, kept running in digital loopback, dropped in calibration
    always_ff @(posedge clk) begin
        if (srst) begin
            dac_data       <= 32'h0000_0000;
            dac_data_valid <= 1'b0;
        end else if (ce) begin
            dac_data_valid <= 1'b0;
            if (frame_done && data_mode_q && cal_state == cclb_pkg::CAL_IDLE) begin
                dac_data       <= rx_next[63:32];
                dac_data_valid <= 1'b1;
            end
        end
    end

    // Analog path controls
    always_ff @(posedge clk) begin
        if (srst) begin
            ana_ctl       <= '0;
            data_ctl_word <= 32'h0000_0000;
        end else if (ce) begin
            data_ctl_word               <= cw[31:0];
            ana_ctl.monitor_mix_en      <= (cw[cclb_pkg::MON_ATT_LSB +: 4]
                                            != cclb_pkg::MON_ATT_OFF)
                                           && !loop_ana
                                           && (cal_state == cclb_pkg::CAL_IDLE);
            ana_ctl.ext_inputs_connected <= !loop_ana;
            ana_ctl.analog_loop         <= loop_ana;
            ana_ctl.loop_feed_mute      <= loop_ana && !cw[cclb_pkg::BIT_LINE_A_MUTE];
            ana_ctl.line_a_mute         <= !cw[cclb_pkg::BIT_LINE_A_MUTE];
            ana_ctl.line_b_mute         <= !cw[cclb_pkg::BIT_LINE_B_MUTE];
            ana_ctl.speaker_mute        <= !cw[cclb_pkg::BIT_SPK_MUTE];
            ana_ctl.mic_gain_bypass     <= cw[cclb_pkg::BIT_MIC_BYPASS];
            ana_ctl.output_level_select <= cw[cclb_pkg::BIT_OUT_LEVEL];
            ana_ctl.stereo_select       <= cw[cclb_pkg::BIT_STEREO];
            ana_ctl.format_select       <= cw[cclb_pkg::FMT_LSB +: 2];
            ana_ctl.rate_select         <= cw[cclb_pkg::RATE_LSB +: 3];
        end
    end

    // Clock source selection
    always_comb begin
        direct_src = 1'b0;
        unique case (clk_src)
            cclb_pkg::CLK_SCLK: begin
                src_lvl    = sclk_level;
                direct_src = 1'b1;
            end
            cclb_pkg::CLK_XTAL_A:  src_lvl = crystal_input_a;
            cclb_pkg::CLK_XTAL_B:  src_lvl = crystal_input_b;
            cclb_pkg::CLK_EXT_256: begin
                src_lvl    = ext_clock_input;
                direct_src = 1'b1;
            end
            cclb_pkg::CLK_EXT_DIV: src_lvl = ext_clock_input;
            default:               src_lvl = crystal_input_a;
        endcase
    end

    assign div_sel    = cclb_pkg::RATE_DIV[cw[cclb_pkg::RATE_LSB +: 3]];
    assign next_phase = phase_acc + cclb_pkg::PHASE_STEP;

    // Fractional divider: 256 per source edge, toggle each time the divide factor is passed
    always_ff @(posedge clk) begin
        if (srst) begin
            src_q      <= 1'b0;
            phase_acc  <= 13'h0000;
            clk256_out <= 1'b0;
        end else if (ce) begin
            src_q <= src_lvl;
            if (direct_src) begin
                clk256_out <= src_lvl;
                phase_acc  <= 13'h0000;
            end else if (src_lvl != src_q) begin
                if (next_phase >= {1'b0, div_sel}) begin
                    phase_acc  <= next_phase - {1'b0, div_sel};
                    clk256_out <= !clk256_out;
                end else begin
                    phase_acc <= next_phase;
                end
            end
        end
    end

    // Checks
    sequence s_enter_data;
        ce && !data_mode_q && data_mode;
    endsequence

    sequence s_leave_data;
        ce && data_mode_q && !data_mode && !power_down;
    endsequence

    a_fixed_status: assert property (@(posedge clk) disable iff (srst)
        cw[63:61] == 3'b001 && !cw[57] && cw[55:54] == 2'b00)
        else $error("fixed control bits changed");

    a_cal_entry: assert property (@(posedge clk) disable iff (srst)
        s_enter_data |=> cal_state == cclb_pkg::CAL_RUN ##1 (calibrating_flag || !ce))
        else $error("calibration not started on entering data mode");

    a_data_reload: assert property (@(posedge clk) disable iff (srst)
        s_leave_data |=> cw[31:0] == cclb_pkg::CW_DEFAULT[31:0])
        else $error("data mode bits not reloaded");

    a_pd_default: assert property (@(posedge clk) disable iff (srst)
        ce && power_down |=> cw == cclb_pkg::CW_DEFAULT)
        else $error("power-down did not restore defaults");

    a_monitor_loop: assert property (@(posedge clk) disable iff (srst)
        ce && loop_ana |=> !ana_ctl.monitor_mix_en && !ana_ctl.ext_inputs_connected)
        else $error("monitor or inputs active in analog loopback");

    a_monitor_cal: assert property (@(posedge clk) disable iff (srst)
        ce && cal_state == cclb_pkg::CAL_RUN |=> !ana_ctl.monitor_mix_en)
        else $error("monitor mix active during calibration");

    a_feed_mute: assert property (@(posedge clk) disable iff (srst)
        ce && loop_ana && !cw[cclb_pkg::BIT_LINE_A_MUTE] |=> ana_ctl.loop_feed_mute)
        else $error("looped signal not muted with line output A");

    a_cal_length: assert property (@(posedge clk) disable iff (srst)
        ce && frame_start && cal_state == cclb_pkg::CAL_RUN
        && cal_cnt == cclb_pkg::AUTOCAL_FRAMES - 8'h01 |=> cal_state == cclb_pkg::CAL_IDLE)
        else $error("calibration did not end after its frame count");

    a_dac_ignore: assert property (@(posedge clk) disable iff (srst)
        cal_state == cclb_pkg::CAL_RUN |=> !dac_data_valid)
        else $error("DAC data taken during calibration");

    a_echo_bit: assert property (@(posedge clk) disable iff (srst)
        ce && bit_strobe && loop_dig
        |=> serial_out_pin == $past(echo_line[cclb_pkg::ECHO_BITS-1]))
        else $error("echo bit not taken from two frames back");

    a_dac_take: assert property (@(posedge clk) disable iff (srst)
        ce && frame_done && data_mode_q && cal_state == cclb_pkg::CAL_IDLE
        |=> dac_data_valid && dac_data == $past(rx_next[63:32]))
        else $error("DAC word not taken at frame end");

    a_cal_flag: assert property (@(posedge clk) disable iff (srst)
        ce && cal_state == cclb_pkg::CAL_RUN |=> calibrating_flag)
        else $error("calibrating flag low during calibration");

    a_loop_route: assert property (@(posedge clk) disable iff (srst)
        ce && loop_ana |=> ana_ctl.analog_loop)
        else $error("analog loop not routed while selected");

endmodule : cclb_codec_ctl

/* File: rtl/cclb_pkg.sv */
// Shared constants, types and control word layout for the codec control and loopback block
package cclb_pkg;

    // Control word geometry
    localparam int CW_BITS    = 64;
    localparam int FRAME_BITS = 64;
    localparam int ECHO_BITS  = 2 * FRAME_BITS;

    // Values after reset and fixed bits
    localparam logic [63:0] CW_DEFAULT    = 64'h2000_0000_0000_000F;
    localparam logic [63:0] CW_FIXED_MASK = 64'hE2C0_0000_0000_0000;
    localparam logic [63:0] CW_FIXED_VAL  = 64'h2000_0000_0000_0000;
    localparam logic [63:0] CW_CTL_MASK   = 64'h1D3F_FFFF_0000_0000;
    localparam logic [63:0] CW_DATA_MASK  = 64'h0000_0000_FFFF_FFFF;

    // Field positions in the control word
    localparam int BIT_MIC_BYPASS  = 60;
    localparam int BIT_OUT_LEVEL   = 59;
    localparam int BIT_HANDSHAKE   = 58;
    localparam int BIT_AUTOCAL     = 56;
    localparam int RATE_LSB        = 51;
    localparam int BIT_STEREO      = 50;
    localparam int FMT_LSB         = 48;
    localparam int CLKSRC_LSB      = 44;
    localparam int BIT_LOOP_EN     = 33;
    localparam int BIT_LOOP_ANA    = 32;
    localparam int BIT_LINE_A_MUTE = 15;
    localparam int BIT_LINE_B_MUTE = 14;
    localparam int BIT_SPK_MUTE    = 6;
    localparam int MON_ATT_LSB     = 0;
    localparam logic [3:0] MON_ATT_OFF = 4'hF;

    // Autocalibration length in frames
    localparam logic [7:0] AUTOCAL_FRAMES = 8'hC2;

    // Rate divide factors, indexed by the rate select field
    localparam logic [11:0] RATE_DIV [8] = '{
        12'hC00, 12'h600, 12'h380, 12'h300, 12'h1C0, 12'h180, 12'h200, 12'hA00
    };
    // Phase step per source edge, two edges per source period
    localparam logic [12:0] PHASE_STEP = 13'h0100;

    typedef enum logic [2:0] {
        CLK_SCLK,
        CLK_XTAL_A,
        CLK_XTAL_B,
        CLK_EXT_256,
        CLK_EXT_DIV
    } cclb_clk_src_e;

    typedef enum logic {
        CAL_IDLE,
        CAL_RUN
    } cclb_cal_state_e;

    typedef struct packed {
        logic       monitor_mix_en;
        logic       ext_inputs_connected;
        logic       analog_loop;
        logic       loop_feed_mute;
        logic       line_a_mute;
        logic       line_b_mute;
        logic       speaker_mute;
        logic       mic_gain_bypass;
        logic       output_level_select;
        logic       stereo_select;
        logic [1:0] format_select;
        logic [2:0] rate_select;
    } cclb_ana_ctl_s;

endpackage : cclb_pkg

/* File: testbench/cclb_host_model.sv */
// Host model that sends framed serial words and captures the reply
`timescale 1ns/1ps
module cclb_host_model (
    // Clock
    input  wire logic clk,
    // Serial link
    output logic      bit_strobe,
    output logic      frame_sync,
    output logic      serial_in_pin,
    input  wire logic serial_out_pin
);
    initial begin
        bit_strobe    = 1'b0;
        frame_sync    = 1'b0;
        serial_in_pin = 1'b0;
    end

    // One frame MSB first, strobes two cycles apart, data line flips off strobe
    task automatic xfer(input logic [63:0] tx, output logic [63:0] rx);
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            if (i > 0) rx[64 - i] = serial_out_pin;
            bit_strobe    <= 1'b1;
            frame_sync    <= (i == 0);
            serial_in_pin <= tx[63 - i];
            @(posedge clk);
            bit_strobe    <= 1'b0;
            frame_sync    <= 1'b0;
            serial_in_pin <= ~tx[63 - i];
        end
        @(posedge clk);
        rx[0] = serial_out_pin;
    endtask : xfer
endmodule : cclb_host_model

/* File: testbench/test_codec_control_loopback.sv */
// Self-checking testbench of the codec control and loopback block
`timescale 1ns/1ps
module test_codec_control_loopback;
    logic                    clk        = 1'b0;
    logic                    srst       = 1'b1;
    logic                    ce         = 1'b1;
    logic                    data_mode  = 1'b0;
    logic                    power_down = 1'b0;
    logic                    src_tog    = 1'b0;
    logic [1:0]              src_div    = 2'h0;
    logic [31:0]             adc_data   = 32'h5A5A_C3C3;
    logic                    bit_strobe;
    logic                    frame_sync;
    logic                    serial_in_pin;
    logic                    serial_out_pin;
    logic                    clk256_out;
    logic [31:0]             dac_data;
    logic [31:0]             data_ctl_word;
    logic                    dac_data_valid;
    logic                    calibrating_flag;
    cclb_pkg::cclb_ana_ctl_s ana_ctl;
    int                      num_errors   = 0;
    int                      total_checks = 0;
    int                      valid_cnt    = 0;
    logic [63:0]             rx;

    always #2 clk = ~clk;

    // Source clock at one eighth of clk feeds every source input
    always @(posedge clk) begin
        src_div <= src_div + 2'h1;
        if (src_div == 2'h3) src_tog <= ~src_tog;
        if (dac_data_valid === 1'b1) valid_cnt <= valid_cnt + 1;
    end

    cclb_codec_ctl dut (
        .clk(clk), .srst(srst), .ce(ce), .data_mode(data_mode), .power_down(power_down),
        .bit_strobe(bit_strobe), .frame_sync(frame_sync), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .crystal_input_a(src_tog),
        .crystal_input_b(src_tog), .ext_clock_input(src_tog), .sclk_level(src_tog),
        .clk256_out(clk256_out), .adc_data(adc_data), .dac_data(dac_data),
        .dac_data_valid(dac_data_valid), .data_ctl_word(data_ctl_word),
        .ana_ctl(ana_ctl), .calibrating_flag(calibrating_flag)
    );

    cclb_host_model host (
        .clk(clk), .bit_strobe(bit_strobe), .frame_sync(frame_sync),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin)
    );

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : chk

    // Counts output clock edges over 1536 cycles
    task automatic chk_rate(input string what, input int exp);
        int   n;
        logic last;
        n = 0;
        repeat (64) @(posedge clk);
        last = clk256_out;
        repeat (1536) begin
            @(posedge clk);
            if (clk256_out !== last) n++;
            last = clk256_out;
        end
        total_checks++;
        if (n < exp - 4 || n > exp + 4) begin
            $display("[FAIL] %s expected %0d seen %0d", what, exp, n);
            num_errors++;
        end
    endtask : chk_rate

    task automatic t_defaults;
        host.xfer(64'h0, rx);
        chk("readback", cclb_pkg::CW_DEFAULT, rx);
        chk("line_a_mute", 1'b1, ana_ctl.line_a_mute);
        chk("monitor_mix_en", 1'b0, ana_ctl.monitor_mix_en);
        chk("calibrating_flag", 1'b1, calibrating_flag);
        chk("data_ctl_word", 32'h0000_000F, data_ctl_word);
        chk_rate("sclk 256x", 384);
    endtask : t_defaults

    task automatic t_fields;
        host.xfer(64'hFFEE_1000_FFFF_FFFF, rx);
        repeat (2) @(posedge clk);
        chk("rate_select", 3'h5, ana_ctl.rate_select);
        chk("stereo_select", 1'b1, ana_ctl.stereo_select);
        chk("format_select", 2'h2, ana_ctl.format_select);
        chk("mic_gain_bypass", 1'b1, ana_ctl.mic_gain_bypass);
        chk("output_level", 1'b1, ana_ctl.output_level_select);
        chk_rate("xtal_a rate 5", 256);
        host.xfer(64'h0000_2000_0000_0000, rx);
        chk("fixed ones", 64'h3D2E_1000_0000_000F, rx);
        chk_rate("xtal_b rate 0", 32);
        host.xfer(64'h0000_3000_0000_0000, rx);
        chk("fixed zeros", 64'h2000_2000_0000_000F, rx);
        chk_rate("ext 256x", 384);
        host.xfer(64'h0000_4000_0000_0000, rx);
        chk("ext source", 64'h2000_3000_0000_000F, rx);
        chk_rate("ext divided rate 0", 32);
    endtask : t_fields

    task automatic t_digital_loop;
        host.xfer(64'h0000_0002_0000_0000, rx);
        chk("before loop", 64'h2000_4000_0000_000F, rx);
        host.xfer(64'h3C2A_1002_A5C3_5A3C, rx);
        host.xfer(64'h1D15_0002_0F0F_F0F0, rx);
        host.xfer(64'h0000_0002_1357_9BDF, rx);
        chk("echo frame 3", 64'h3C2A_1002_A5C3_5A3C, rx);
        host.xfer(64'h0000_0002_0000_0000, rx);
        chk("echo frame 4", 64'h1D15_0002_0F0F_F0F0, rx);
    endtask : t_digital_loop

    task automatic t_analog_loop;
        host.xfer(64'h0000_0001_0000_0000, rx);
        repeat (2) @(posedge clk);
        chk("loop off", 1'b0, ana_ctl.analog_loop);
        chk("inputs on", 1'b1, ana_ctl.ext_inputs_connected);
        host.xfer(64'h0000_0003_0000_0000, rx);
        repeat (2) @(posedge clk);
        chk("analog_loop", 1'b1, ana_ctl.analog_loop);
        chk("inputs off", 1'b0, ana_ctl.ext_inputs_connected);
        chk("mix off", 1'b0, ana_ctl.monitor_mix_en);
        host.xfer(64'h0000_0003_0000_0000, rx);
        chk("no echo", 64'h2000_0003_0000_000F, rx);
    endtask : t_analog_loop

    task automatic t_data_mode;
        int v;
        v = valid_cnt;
        data_mode <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 195; i++) begin
            host.xfer(64'h8421_7BDE_0000_C040, rx);
            if (i == 1) chk("mix in cal", 1'b0, ana_ctl.monitor_mix_en);
            if (i == 192) chk("cal at 193", 1'b1, calibrating_flag);
            if (i == 192) chk("dac in cal", v, valid_cnt);
        end
        repeat (3) @(posedge clk);
        chk("cal done", 1'b0, calibrating_flag);
        v = valid_cnt;
        host.xfer(64'h8421_7BDE_0000_C040, rx);
        repeat (3) @(posedge clk);
        chk("adc out", 32'h5A5A_C3C3, rx[63:32]);
        chk("ctl out", 32'h0000_C040, rx[31:0]);
        chk("dac_data", 32'h8421_7BDE, dac_data);
        chk("dac pulses", v + 1, valid_cnt);
        chk("data_ctl_word", 32'h0000_C040, data_ctl_word);
        chk("feed unmuted", 1'b0, ana_ctl.loop_feed_mute);
        chk("mix in loop", 1'b0, ana_ctl.monitor_mix_en);
        host.xfer(64'h1357_2468_0000_4040, rx);
        repeat (3) @(posedge clk);
        chk("line_a_mute", 1'b1, ana_ctl.line_a_mute);
        chk("feed muted", 1'b1, ana_ctl.loop_feed_mute);
        chk("line_b_mute", 1'b0, ana_ctl.line_b_mute);
        data_mode <= 1'b0;
        repeat (3) @(posedge clk);
        chk("low defaults", 32'h0000_000F, data_ctl_word);
        host.xfer(64'h0000_0003_0000_0000, rx);
        chk("control kept", 64'h2000_0003_0000_000F, rx);
    endtask : t_data_mode

    task automatic t_power_down;
        ce         <= 1'b0;
        power_down <= 1'b1;
        repeat (2) @(posedge clk);
        ce         <= 1'b1;
        power_down <= 1'b0;
        repeat (2) @(posedge clk);
        chk("frozen by ce", 1'b1, ana_ctl.analog_loop);
        power_down <= 1'b1;
        repeat (2) @(posedge clk);
        power_down <= 1'b0;
        host.xfer(64'h0, rx);
        chk("after power down", cclb_pkg::CW_DEFAULT, rx);
        chk("loop cleared", 1'b0, ana_ctl.analog_loop);
        data_mode <= 1'b1;
        repeat (2) @(posedge clk);
        host.xfer(64'h0000_0000_0000_C040, rx);
        repeat (2) @(posedge clk);
        chk("mix in recal", 1'b0, ana_ctl.monitor_mix_en);
        data_mode <= 1'b0;
    endtask : t_power_down

    task automatic wrap_up;
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_defaults();
        t_fields();
        t_digital_loop();
        t_analog_loop();
        t_data_mode();
        t_power_down();
        wrap_up();
    end

    initial begin
        #(80000 * 4);
        num_errors++;
        wrap_up();
    end
endmodule : test_codec_control_loopback
